// [crr_params.svh]
// Offsets, field positions, reset values and counts of the reflection result registers
`ifndef CRR_PARAMS_SVH
`define CRR_PARAMS_SVH

// Register indices; the byte address on the bus is four times the index
`define CRR_IDX_PAIR_D_PEAK_DIST_HI 10'h199
`define CRR_IDX_PEAK_AMPLITUDE_1 10'h19a
`define CRR_IDX_PEAK_AMPLITUDE_2 10'h19b
`define CRR_IDX_PEAK_AMPLITUDE_3 10'h19c
`define CRR_IDX_PEAK_AMPLITUDE_4 10'h19d
`define CRR_IDX_PEAK_AMPLITUDE_5 10'h19e
`define CRR_IDX_PEAK_AMPLITUDE_6 10'h19f
`define CRR_IDX_RESULT_CTRL 10'h1b0
`define CRR_IDX_RESULT_STATUS 10'h1b1

// Field positions
`define CRR_HI_FIELD_LSB 8
`define CRR_LO_FIELD_LSB 0
`define CRR_CTRL_CAPTURE_EN_BIT 0
`define CRR_CTRL_CLEAR_BIT 1
`define CRR_STAT_OVERFLOW_LSB 0
`define CRR_STAT_COUNT_LSB 4

// Reset values
`define CRR_RESULT_RESET 16'h0000
`define CRR_CTRL_RESET 32'h0000_0001

// Counts
`define CRR_MAX_PEAKS 5
`define CRR_PAIRS 4

`endif

// [crr_pkg.sv]
// Types shared by the reflection result register bank
package crr_pkg;

	typedef enum logic [1:0] {
		CRR_PAIR_A = 2'h0,
		CRR_PAIR_B = 2'h1,
		CRR_PAIR_C = 2'h2,
		CRR_PAIR_D = 2'h3
	} crr_pair_t;

	typedef enum logic [1:0] {
		CRR_BUS_IDLE = 2'b01,
		CRR_BUS_ACK = 2'b10
	} crr_bus_state_t;

endpackage : crr_pkg

// [crr_pair_track.sv]
// Per-pair peak slot counter and overflow flag
`timescale 1ns/1ps
`include "crr_params.svh"

module crr_pair_track #(
	parameter int MAX_PEAKS = `CRR_MAX_PEAKS
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic clear,
	input wire logic hit,
	output logic [2:0] slot,
	output logic store,
	output logic [2:0] count_q,
	output logic overflow_q
);

	logic full;
	logic [2:0] count_d;

	assign full = (count_q == 3'(MAX_PEAKS));
	// A peak arriving with the clear starts the new run in slot zero
	assign slot = clear ? 3'h0 : count_q;
	assign store = hit && (clear || !full);

	always_comb begin
		if (clear) begin
			count_d = hit ? 3'h1 : 3'h0;
		end else if (hit && !full) begin
			count_d = count_q + 3'h1;
		end else begin
			count_d = count_q;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			count_q <= 3'h0;
		end else begin
			count_q <= count_d;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			overflow_q <= 1'b0;
		end else if (hit && !clear && full) begin
			overflow_q <= 1'b1;
		end else if (clear) begin
			overflow_q <= 1'b0;
		end
	end

endmodule : crr_pair_track

// [crr_result_regs.sv]
// Cable reflection result registers with an Avalon-MM slave port
`timescale 1ns/1ps
`include "crr_params.svh"

// Notes on behaviour
// - 0x0199: pair D peak 5 high, peak 4 low
// - Distance fields hold distance to reflection point
// - 0x019A: pair A peaks 2 and 1 amplitude
// - Amplitude fields hold reflection strength
// - 0x019B: pair A peaks 4 and 3 amplitude
// - 0x019C: pair B peak 1, pair A peak 5
// - 0x019D: pair B peaks 3 and 2 amplitude
// - 0x019E: pair B peaks 5 and 4 amplitude
// - 0x019F: pair C peaks 2 and 1 amplitude
// - Five peaks per pair; more sets overflow
module crr_result_regs
	import crr_pkg::*;
#(
	parameter int DIST_W = 8,
	parameter int AMP_W = 7,
	parameter int MAX_PEAKS = `CRR_MAX_PEAKS
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [11:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic diag_start,
	input wire logic peak_valid,
	input wire logic [1:0] peak_pair,
	input wire logic [DIST_W-1:0] peak_distance,
	input wire logic [AMP_W-1:0] peak_amplitude,
	output logic [3:0] pair_peak_overflow_q
);

	crr_bus_state_t state_q;
	logic [9:0] index;
	logic capture_en_q;
	logic clear_req_q;
	logic clear_all;
	logic [3:0] hit;
	logic [2:0] slot [0:3];
	logic [3:0] store;
	logic [2:0] count [0:3];
	logic [3:0] overflow;
	logic [AMP_W-1:0] amp_a_q [0:4];
	logic [AMP_W-1:0] amp_b_q [0:4];
	logic [AMP_W-1:0] amp_c_q [0:1];
	logic [DIST_W-1:0] dist_d_q [0:1];
	logic [31:0] read_d;
	logic write_take;
	logic bus_take;
	logic ctrl_write;
	logic keep_c;
	logic keep_d;
	logic [31:0] status_word;

	assign index = avs_address[11:2];
	// Taken only while idle, so a request still held at the ack edge is not taken twice
	assign bus_take = (state_q == CRR_BUS_IDLE) && (avs_read || avs_write);
	// Write takes effect only at the edge where waitrequest is sampled low
	assign write_take = (state_q == CRR_BUS_ACK) && avs_write;
	assign ctrl_write = write_take && (index == `CRR_IDX_RESULT_CTRL) && avs_byteenable[0];
	assign clear_all = diag_start || clear_req_q;
	// Pair C keeps slots zero and one here, pair D slots three and four
	assign keep_c = store[CRR_PAIR_C] && (slot[CRR_PAIR_C] < 3'h2);
	assign keep_d = store[CRR_PAIR_D] && (slot[CRR_PAIR_D] >= 3'h3);

	// One tracker per pair; overflow is flagged past the fifth peak
	genvar gp;
	generate
		for (gp = 0; gp < 4; gp++) begin : g_pair
			assign hit[gp] = peak_valid && capture_en_q && (peak_pair == 2'(gp));
			crr_pair_track #(
				.MAX_PEAKS(MAX_PEAKS)
			) u_track (
				.clock(clock),
				.sys_rst(sys_rst),
				.clear(clear_all),
				.hit(hit[gp]),
				.slot(slot[gp]),
				.store(store[gp]),
				.count_q(count[gp]),
				.overflow_q(overflow[gp])
			);
		end
	endgenerate

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pair_peak_overflow_q <= 4'h0;
		end else begin
			pair_peak_overflow_q <= overflow;
		end
	end

	// Result storage: written by the engine only, never by the bus
	// Pair A keeps all five amplitudes
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			for (int i = 0; i < 5; i++) begin
				amp_a_q[i] <= '0;
			end
		end else begin
			if (clear_all) begin
				for (int i = 0; i < 5; i++) begin
					amp_a_q[i] <= '0;
				end
			end
			// Store follows the clear so a peak in the clear cycle survives
			if (store[CRR_PAIR_A]) begin
				amp_a_q[slot[CRR_PAIR_A]] <= peak_amplitude;
			end
		end
	end

	// Pair B keeps all five amplitudes
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			for (int i = 0; i < 5; i++) begin
				amp_b_q[i] <= '0;
			end
		end else begin
			if (clear_all) begin
				for (int i = 0; i < 5; i++) begin
					amp_b_q[i] <= '0;
				end
			end
			if (store[CRR_PAIR_B]) begin
				amp_b_q[slot[CRR_PAIR_B]] <= peak_amplitude;
			end
		end
	end

	// Pair C keeps only its first two amplitudes here
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			amp_c_q[0] <= '0;
			amp_c_q[1] <= '0;
		end else begin
			if (clear_all) begin
				amp_c_q[0] <= '0;
				amp_c_q[1] <= '0;
			end
			if (keep_c) begin
				amp_c_q[slot[CRR_PAIR_C][0]] <= peak_amplitude;
			end
		end
	end

	// Only peaks four and five of pair D have their distance here
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			dist_d_q[0] <= '0;
			dist_d_q[1] <= '0;
		end else begin
			if (clear_all) begin
				dist_d_q[0] <= '0;
				dist_d_q[1] <= '0;
			end
			if (keep_d) begin
				dist_d_q[slot[CRR_PAIR_D][0] ? 0 : 1] <= peak_distance;
			end
		end
	end

	// Control: capture enable and a self-clearing clear request
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			capture_en_q <= 1'(`CRR_CTRL_RESET);
		end else if (ctrl_write) begin
			capture_en_q <= avs_writedata[`CRR_CTRL_CAPTURE_EN_BIT];
		end
	end

	// Pulses for one cycle, so the clear bit always reads back zero
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			clear_req_q <= 1'b0;
		end else begin
			clear_req_q <= ctrl_write && avs_writedata[`CRR_CTRL_CLEAR_BIT];
		end
	end

	// Status word: overflow flag and three-bit peak count per pair
	always_comb begin
		status_word = 32'h0000_0000;
		for (int p = 0; p < 4; p++) begin
			status_word[`CRR_STAT_OVERFLOW_LSB + p] = overflow[p];
			status_word[`CRR_STAT_COUNT_LSB + 4 * p +: 3] = count[p];
		end
	end

	// Read mux; reserved bits 15 and 7 of amplitude words read zero
	always_comb begin
		read_d = 32'h0000_0000;
		case (index)
			`CRR_IDX_PAIR_D_PEAK_DIST_HI: begin
				read_d[15:8] = dist_d_q[1];
				read_d[7:0] = dist_d_q[0];
			end
			`CRR_IDX_PEAK_AMPLITUDE_1: begin
				read_d[14:8] = amp_a_q[1];
				read_d[6:0] = amp_a_q[0];
			end
			`CRR_IDX_PEAK_AMPLITUDE_2: begin
				read_d[14:8] = amp_a_q[3];
				read_d[6:0] = amp_a_q[2];
			end
			`CRR_IDX_PEAK_AMPLITUDE_3: begin
				read_d[14:8] = amp_b_q[0];
				read_d[6:0] = amp_a_q[4];
			end
			`CRR_IDX_PEAK_AMPLITUDE_4: begin
				read_d[14:8] = amp_b_q[2];
				read_d[6:0] = amp_b_q[1];
			end
			`CRR_IDX_PEAK_AMPLITUDE_5: begin
				read_d[14:8] = amp_b_q[4];
				read_d[6:0] = amp_b_q[3];
			end
			`CRR_IDX_PEAK_AMPLITUDE_6: begin
				read_d[14:8] = amp_c_q[1];
				read_d[6:0] = amp_c_q[0];
			end
			`CRR_IDX_RESULT_CTRL: begin
				read_d[`CRR_CTRL_CAPTURE_EN_BIT] = capture_en_q;
			end
			`CRR_IDX_RESULT_STATUS: begin
				read_d = status_word;
			end
			default: begin
				read_d = 32'h0000_0000;
			end
		endcase
	end

	// Bus handshake: one wait cycle, then a one-cycle acknowledge
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state_q <= CRR_BUS_IDLE;
		end else begin
			case (state_q)
				CRR_BUS_IDLE: begin
					if (bus_take) begin
						state_q <= CRR_BUS_ACK;
					end
				end
				CRR_BUS_ACK: begin
					state_q <= CRR_BUS_IDLE;
				end
				default: begin
					state_q <= CRR_BUS_IDLE;
				end
			endcase
		end
	end

	// Low only in the acknowledge cycle
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= !bus_take;
		end
	end

	// Stands until the next request is answered
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			avs_readdata <= 32'h0000_0000;
		end else if (bus_take) begin
			// Writes to result words fall through here unused
			avs_readdata <= avs_read ? read_d : 32'h0000_0000;
		end
	end

endmodule : crr_result_regs

// [crr_result_regs_sva.sv]
// Bus and overflow checks for the reflection result registers
`timescale 1ns/1ps
module crr_result_regs_sva #(
	parameter int DIST_W = 8,
	parameter int AMP_W = 7,
	parameter int MAX_PEAKS = 5
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [11:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic diag_start,
	input wire logic peak_valid,
	input wire logic [1:0] peak_pair,
	input wire logic [DIST_W-1:0] peak_distance,
	input wire logic [AMP_W-1:0] peak_amplitude,
	input wire logic [3:0] pair_peak_overflow_q
);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	wire logic req = avs_read || avs_write;
	sequence taken_s; req && avs_waitrequest; endsequence
	sequence ack_s; !avs_waitrequest ##1 avs_waitrequest; endsequence
	a_ack_one_cycle: assert property (taken_s |=> ack_s)
		else $error("Request not acknowledged in one cycle");
	a_no_idle_ack: assert property (!req && avs_waitrequest |=> avs_waitrequest)
		else $error("Acknowledge without request");
	a_amp_rsvd_zero: assert property (!avs_waitrequest && avs_read
		&& avs_address[11:2] inside {[10'h19a:10'h19f]} |-> avs_readdata[31:15] == 0
		&& !avs_readdata[7]) else $error("Reserved bits set");
	a_dist_upper_zero: assert property (!avs_waitrequest && avs_read
		&& avs_address[11:2] == 10'h199 |-> avs_readdata[31:16] == 0)
		else $error("Upper half of distance word set");
	a_rdata_stands: assert property (avs_waitrequest |-> $stable(avs_readdata))
		else $error("Read data changed while idle");
	a_reset_clears: assert property (disable iff (1'b0) sys_rst |=> avs_waitrequest
		&& avs_readdata == 0 && pair_peak_overflow_q == 0) else $error("Reset not cleared");
	a_ovf_start_clear: assert property (diag_start |=> ##1 pair_peak_overflow_q == 0)
		else $error("Overflow kept across start");
	a_ovf_needs_peak: assert property ($rose(pair_peak_overflow_q[0]) |->
		$past(peak_valid, 2) && $past(peak_pair, 2) == 2'h0) else $error("Overflow without peak");
	a_ovf_sticky: assert property ($fell(pair_peak_overflow_q[0]) |->
		$past(diag_start, 2) || $past(avs_write, 3)) else $error("Overflow dropped");
endmodule : crr_result_regs_sva

bind crr_result_regs crr_result_regs_sva #(.DIST_W(DIST_W), .AMP_W(AMP_W),
	.MAX_PEAKS(MAX_PEAKS)) u_sva (.clock, .sys_rst, .avs_address, .avs_read,
	.avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
	.diag_start, .peak_valid, .peak_pair, .peak_distance, .peak_amplitude,
	.pair_peak_overflow_q);

// [crr_result_regs_tb.sv]
// Register level bench for the reflection result registers
`timescale 1ns/1ps
module crr_result_regs_tb;
	logic clock, sys_rst, avs_read, avs_write, avs_waitrequest;
	logic diag_start, peak_valid;
	logic [11:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [3:0] avs_byteenable, ovf;
	logic [1:0] peak_pair;
	logic [7:0] peak_distance;
	logic [6:0] peak_amplitude;
	int failures = 0;
	int compares = 0;
	int cycles = 0;

	crr_result_regs u_crr_result_regs (.clock, .sys_rst, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
		.diag_start, .peak_valid, .peak_pair, .peak_distance, .peak_amplitude,
		.pair_peak_overflow_q(ovf));

	always #10 clock = ~clock;

	task conclude;
		$display("Checks %0d, errors %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : conclude

	// Generous ceiling; the whole sequence needs under two hundred cycles
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			failures++;
			conclude();
		end
	end

	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			failures++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	// Edge first, so a release and the next raise never share a time step
	task bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		@(posedge clock);
		avs_address <= a;
		avs_writedata <= wd;
		avs_write <= wr;
		avs_read <= !wr;
		do @(posedge clock); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	function automatic logic [6:0] amp(int n);
		return 7'(n / 5 * 16 + n % 5 + 1);
	endfunction : amp

	task check_all(input bit zero);
		for (int i = 0; i < 7; i++) begin
			bus(1'b0, 12'(12'h664 + 4 * i), 32'h0);
			if (zero || i == 0)
				chk("result", zero ? 32'h0 : 32'h0000d5d4, rd);
			else
				chk("result", {17'h0, amp(2 * i - 1), 1'b0, amp(2 * i - 2)}, rd);
		end
	endtask : check_all

	task start;
		@(posedge clock);
		diag_start <= 1'b1;
		@(posedge clock);
		diag_start <= 1'b0;
	endtask : start

	// Back-to-back peaks 1..n on one pair, then the strobe drops
	task peaks(input int p, input int n);
		for (int k = 1; k <= n; k++) begin
			@(posedge clock);
			peak_valid <= 1'b1;
			peak_pair <= 2'(p);
			peak_distance <= 8'(8'ha0 + p * 16 + k);
			peak_amplitude <= 7'(p * 16 + k);
		end
		@(posedge clock);
		peak_valid <= 1'b0;
	endtask : peaks

	initial begin
		clock = 0;
		sys_rst = 1;
		{avs_read, avs_write, diag_start, peak_valid} = 4'h0;
		{avs_address, avs_writedata, peak_pair, peak_distance, peak_amplitude} = '0;
		avs_byteenable = 4'hf;
		repeat (3) @(posedge clock);
		sys_rst <= 1'b0;
		check_all(1'b1);
		start();
		// Pair A gets a sixth peak to overflow
		for (int p = 0; p < 4; p++)
			peaks(p, 5 + (p == 0));
		repeat (2) @(posedge clock);
		chk("overflow", 32'h1, {28'h0, ovf});
		bus(1'b0, 12'h6c4, 32'h0);
		chk("status", 32'h0005_5551, rd);
		check_all(1'b0);
		for (int i = 0; i < 7; i++)
			bus(1'b1, 12'(12'h664 + 4 * i), 32'hffffffff);
		check_all(1'b0);
		bus(1'b0, 12'h700, 32'h0);
		chk("unmapped", 32'h0, rd);
		// Control clear drops results and overflow; capture off ignores peaks
		bus(1'b1, 12'h6c0, 32'h2);
		bus(1'b0, 12'h6c4, 32'h0);
		chk("status", 32'h0, rd);
		chk("overflow", 32'h0, {28'h0, ovf});
		peaks(0, 1);
		bus(1'b0, 12'h6c4, 32'h0);
		chk("status", 32'h0, rd);
		bus(1'b0, 12'h668, 32'h0);
		chk("result", 32'h0, rd);
		bus(1'b0, 12'h6c0, 32'h0);
		chk("control", 32'h0, rd);
		bus(1'b1, 12'h6c0, 32'h1);
		peaks(1, 6);
		bus(1'b0, 12'h6c4, 32'h0);
		chk("status", 32'h0000_0502, rd);
		chk("overflow", 32'h2, {28'h0, ovf});
		bus(1'b0, 12'h670, 32'h0);
		chk("result", 32'h0000_1100, rd);
		start();
		repeat (2) @(posedge clock);
		chk("overflow", 32'h0, {28'h0, ovf});
		check_all(1'b1);
		conclude();
	end
endmodule : crr_result_regs_tb
